//--- hw/flash_engine_consts.vh
// constants for the flash self-programming engine
`ifndef FLASH_ENGINE_CONSTS_VH
`define FLASH_ENGINE_CONSTS_VH
`define OFS_ACCESS_CONTROL   12'h000
`define OFS_OPERATION_TYPE   12'h004
`define OFS_ADDRESS_HIGH     12'h008
`define OFS_ADDRESS_LOW      12'h00C
`define OFS_DATA_BYTE        12'h010
`define OFS_COMMAND_UNLOCK   12'h014
`define OFS_LOWER_BOUND      12'h018
`define OFS_CLOCK_CONTROL    12'h01C
`define OFS_STATUS           12'h020
`define BIT_ENGINE_ENABLE    7
`define OP_STANDBY           3'h0
`define OP_READ              3'h1
`define OP_PROGRAM           3'h2
`define OP_ERASE             3'h3
`define UNLOCK_FIRST         8'h46
`define UNLOCK_SECOND        8'hB9
`define PAGE_BYTES           512
`define PAGE_SHIFT           9
`define DIVIDER_WIDTH        6
`define DIVIDER_RESET        6'h00
`define ERASE_TICKS          5'h10
`define PROGRAM_TICKS        5'h04
`define READ_TICKS           5'h01
`endif

//--- hw/flash_array.v
// flash storage array with and-only programming and page erase
`timescale 1ns/100ps
`include "flash_engine_consts.vh"
module flash_array #(
    parameter ADDR_WIDTH = 15
) (
    input  wire                  clk,
    input  wire                  erase_stb,
    input  wire                  program_stb,
    input  wire                  read_stb,
    input  wire [ADDR_WIDTH-1:0] addr,
    input  wire [7:0]            wdata,
    output reg  [7:0]            rdata
);
    localparam DEPTH = 1 << ADDR_WIDTH;
    reg [7:0] mem [0:DEPTH-1];
    integer   i;

    // no reset on the array: it models non-volatile storage
    always @(posedge clk) begin
        if (erase_stb) begin
            for (i = 0; i < `PAGE_BYTES; i = i + 1) begin
                mem[{addr[ADDR_WIDTH-1:`PAGE_SHIFT], i[`PAGE_SHIFT-1:0]}] <= 8'hFF;
            end
        end else if (program_stb) begin
            mem[addr] <= mem[addr] & wdata;
        end
        if (read_stb) begin
            rdata <= mem[addr];
        end
    end
endmodule

//--- hw/flash_self_programming_engine.v
// flash self-programming engine: apb registers, unlock, region check, sequencer
// How it works
// - boot code may modify application and data regions; application code only data.
// - boot-loader region size comes from a strap, disabled up to four kilobytes.
// - data region spans lower-bound register up to boot-loader start minus one.
// - lower-bound register loads from a strap and stays software writable.
// - only page erase, byte program and byte read are offered.
// - operation select codes erase 011, program 010, read 001.
// - operation starts only after 0x46 then 0xB9 written to the command register.
// - cpu execution is halted until the flash operation completes.
// - program writes the data register into the addressed flash byte.
// - read places the addressed flash byte into the data register.
// - programming only clears bits; only erase sets them back.
// - page erase sets all 512 bytes of an aligned page to ones.
// - engine accepts operations only while enable bit 7 is set.
// - target beyond the data region's last byte is ignored, nothing done.
// - cpu resumes after the operation; pending interrupts then serviced.
`timescale 1ns/100ps
`include "flash_engine_consts.vh"
module flash_self_programming_engine #(
    parameter ADDR_WIDTH = 15
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        running_in_boot,
    input  wire [3:0]  boot_size_strap,
    input  wire [7:0]  lower_bound_strap,
    output wire        cpu_halt
);
    localparam S_IDLE  = 2'h0;
    localparam S_WAIT  = 2'h1;
    localparam S_FIN   = 2'h2;
    localparam [ADDR_WIDTH-1:0] TOP_ADDR = {ADDR_WIDTH{1'b1}};

    reg  [7:0]               access_control_reg;
    reg  [2:0]               operation_type_reg;
    reg  [7:0]               address_high_reg;
    reg  [7:0]               address_low_reg;
    reg  [7:0]               data_byte_reg;
    reg  [7:0]               lower_bound_reg;
    reg  [`DIVIDER_WIDTH-1:0] divider_reg;
    reg                      unlock_armed_reg;
    reg                      strap_loaded_reg;
    reg                      ignored_reg;
    reg  [1:0]               state_reg;
    reg  [2:0]               op_reg;
    reg  [4:0]               ticks_reg;
    reg  [`DIVIDER_WIDTH-1:0] prescale_reg;
    reg  [31:0]              read_word;
    wire [7:0]               flash_rdata;
    wire                     wr_en;
    wire                     rd_en;
    wire                     cmd_wr;
    wire                     trigger;
    wire [ADDR_WIDTH-1:0]    target;
    wire [ADDR_WIDTH-1:0]    boot_start;
    wire [ADDR_WIDTH-1:0]    data_low;
    wire                     op_valid;
    wire                     in_range;
    wire                     tick;

    // a step of 512 bytes per strap count, zero means disabled
    function [ADDR_WIDTH-1:0] region_start;
        input [3:0] pages;
        reg   [ADDR_WIDTH:0] span;
        begin
            span = {{(ADDR_WIDTH-12){1'b0}}, pages, 9'h000};
            region_start = TOP_ADDR - span[ADDR_WIDTH-1:0] + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
        end
    endfunction

    function [4:0] op_ticks;
        input [2:0] op;
        begin
            case (op)
                `OP_ERASE:   op_ticks = `ERASE_TICKS;
                `OP_PROGRAM: op_ticks = `PROGRAM_TICKS;
                default:     op_ticks = `READ_TICKS;
            endcase
        end
    endfunction

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign cmd_wr  = wr_en & (paddr == `OFS_COMMAND_UNLOCK);

    // boot-loader size limited to 8 pages = 4 KiB
    assign boot_start = region_start((boot_size_strap > 4'h8) ? 4'h8 : boot_size_strap);
    assign data_low   = {lower_bound_reg, {(ADDR_WIDTH-8){1'b0}}};
    assign target     = {address_high_reg[ADDR_WIDTH-9:0], address_low_reg};
    assign op_valid   = (operation_type_reg == `OP_ERASE) |
                        (operation_type_reg == `OP_PROGRAM) |
                        (operation_type_reg == `OP_READ);
    // reads allowed anywhere below the boot-loader; writes by region permission
    assign in_range = (boot_size_strap == 4'h0) ? 1'b1 :
                      (target < boot_start);
    wire write_ok   = running_in_boot ? in_range :
                      (in_range & (target >= data_low));
    wire allowed    = (operation_type_reg == `OP_READ) ? in_range : write_ok;
    assign trigger  = cmd_wr & unlock_armed_reg &
                      (pwdata[7:0] == `UNLOCK_SECOND) & (state_reg == S_IDLE);
    assign tick     = (prescale_reg == {`DIVIDER_WIDTH{1'b0}});
    assign cpu_halt = (state_reg != S_IDLE);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_armed_reg <= 1'b0;
        end else if (cmd_wr) begin
            // any other value, including a repeated first, drops the sequence
            unlock_armed_reg <= (pwdata[7:0] == `UNLOCK_FIRST) & ~unlock_armed_reg;
        end else if (trigger) begin
            unlock_armed_reg <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_control_reg <= 8'h00;
            operation_type_reg <= `OP_STANDBY;
            address_high_reg   <= 8'h00;
            address_low_reg    <= 8'h00;
            lower_bound_reg    <= 8'h00;
            divider_reg        <= `DIVIDER_RESET;
            strap_loaded_reg   <= 1'b0;
        end else begin
            if (!strap_loaded_reg) begin
                lower_bound_reg  <= lower_bound_strap;
                strap_loaded_reg <= 1'b1;
            end else if (wr_en && paddr == `OFS_LOWER_BOUND) begin
                lower_bound_reg <= pwdata[7:0];
            end
            if (wr_en && state_reg == S_IDLE) begin
                case (paddr)
                    `OFS_ACCESS_CONTROL: access_control_reg <= pwdata[7:0];
                    `OFS_OPERATION_TYPE: operation_type_reg <= pwdata[2:0];
                    `OFS_ADDRESS_HIGH:   address_high_reg   <= pwdata[7:0];
                    `OFS_ADDRESS_LOW:    address_low_reg    <= pwdata[7:0];
                    `OFS_CLOCK_CONTROL:  divider_reg        <= pwdata[`DIVIDER_WIDTH-1:0];
                    default: ;
                endcase
            end
        end
    end

    // data byte: software write or read result; hardware result wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_byte_reg <= 8'h00;
        end else if (state_reg == S_FIN && op_reg == `OP_READ) begin
            data_byte_reg <= flash_rdata;
        end else if (wr_en && paddr == `OFS_DATA_BYTE && state_reg == S_IDLE) begin
            data_byte_reg <= pwdata[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= S_IDLE;
            op_reg       <= `OP_STANDBY;
            ticks_reg    <= 5'h00;
            prescale_reg <= {`DIVIDER_WIDTH{1'b0}};
            ignored_reg  <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (trigger) begin
                        if (access_control_reg[`BIT_ENGINE_ENABLE] && op_valid &&
                            allowed) begin
                            state_reg    <= S_WAIT;
                            op_reg       <= operation_type_reg;
                            ticks_reg    <= op_ticks(operation_type_reg);
                            prescale_reg <= divider_reg;
                            ignored_reg  <= 1'b0;
                        end else begin
                            ignored_reg <= 1'b1;
                        end
                    end
                end
                S_WAIT: begin
                    // the divider stretches each step, as a real flash needs
                    if (tick) begin
                        prescale_reg <= divider_reg;
                        if (ticks_reg == 5'h01) begin
                            state_reg <= S_FIN;
                        end
                        ticks_reg <= ticks_reg - 5'h01;
                    end else begin
                        prescale_reg <= prescale_reg - {{(`DIVIDER_WIDTH-1){1'b0}}, 1'b1};
                    end
                end
                S_FIN: begin
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // the word is chosen in the setup cycle and held in a flip-flop through the access
    always @* begin
        read_word = 32'h0000_0000;
        case (paddr)
            `OFS_ACCESS_CONTROL: read_word = {24'h000000, access_control_reg};
            `OFS_OPERATION_TYPE: read_word = {29'h00000000, operation_type_reg};
            `OFS_ADDRESS_HIGH:   read_word = {24'h000000, address_high_reg};
            `OFS_ADDRESS_LOW:    read_word = {24'h000000, address_low_reg};
            `OFS_DATA_BYTE:      read_word = {24'h000000, data_byte_reg};
            `OFS_LOWER_BOUND:    read_word = {24'h000000, lower_bound_reg};
            `OFS_CLOCK_CONTROL:  read_word = {26'h0000000, divider_reg};
            `OFS_STATUS:         read_word = {29'h00000000, ignored_reg,
                                              unlock_armed_reg, cpu_halt};
            default:             read_word = 32'h0000_0000;
        endcase
    end

    // zero outside a read, so a stale word never lingers on the bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= read_word;
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    wire last_step = (state_reg == S_WAIT) & tick & (ticks_reg == 5'h01);

    flash_array #(
        .ADDR_WIDTH (ADDR_WIDTH)
    ) u_array (
        .clk         (pclk),
        .erase_stb   (last_step & (op_reg == `OP_ERASE)),
        .program_stb (last_step & (op_reg == `OP_PROGRAM)),
        .read_stb    (last_step & (op_reg == `OP_READ)),
        .addr        (target),
        .wdata       (data_byte_reg),
        .rdata       (flash_rdata)
    );
endmodule

//--- tb/flash_self_programming_engine_monitor.sv
// port-level assertion checker for the flash self-programming engine
`timescale 1ns/100ps
`include "flash_engine_consts.vh"
module flash_self_programming_engine_monitor (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        running_in_boot,
    input logic [3:0]  boot_size_strap,
    input logic [7:0]  lower_bound_strap,
    input logic        cpu_halt
);
    logic       en_reg;
    logic       armed_reg;
    logic [2:0] op_reg;
    logic [5:0] div_reg;
    logic [10:0] halt_cnt;
    logic       wr;
    logic       rd;
    assign wr = psel && penable && pwrite && !cpu_halt;
    assign rd = psel && penable && !pwrite;
    // longest legal freeze: an erase with the slowest divider, plus the finish cycle
    localparam int HALT_MAX = `ERASE_TICKS * (1 << `DIVIDER_WIDTH) + 1;
    function automatic int halt_cycles(input logic [2:0] op, input logic [5:0] dv);
        int steps;
        steps = (op == `OP_ERASE) ? `ERASE_TICKS :
                (op == `OP_PROGRAM) ? `PROGRAM_TICKS : `READ_TICKS;
        return steps * (dv + 1) + 1;
    endfunction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) halt_cnt <= 11'h000;
        else if (cpu_halt) halt_cnt <= halt_cnt + 11'h001;
        else halt_cnt <= 11'h000;
    end
    // shadow of the engine state, rebuilt from bus writes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg    <= 1'b0;
            armed_reg <= 1'b0;
            op_reg    <= 3'h0;
            div_reg   <= `DIVIDER_RESET;
        end else if (wr) begin
            if (paddr == `OFS_CLOCK_CONTROL) div_reg <= pwdata[5:0];
            if (paddr == `OFS_ACCESS_CONTROL) en_reg <= pwdata[`BIT_ENGINE_ENABLE];
            if (paddr == `OFS_OPERATION_TYPE) op_reg <= pwdata[2:0];
            if (paddr == `OFS_COMMAND_UNLOCK)
                armed_reg <= (pwdata[7:0] == `UNLOCK_FIRST) && !armed_reg;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_no_error: assert property (!pslverr) else $error("pslverr raised");
    a_unlock_order: assert property ($rose(cpu_halt) |-> $past(wr && armed_reg
        && paddr == `OFS_COMMAND_UNLOCK && pwdata[7:0] == `UNLOCK_SECOND))
        else $error("halt without unlock pair");
    a_enable_gate: assert property ($rose(cpu_halt) |-> $past(en_reg))
        else $error("operation while disabled");
    a_op_legal: assert property ($rose(cpu_halt) |-> $past(op_reg) != 3'h0
        && $past(op_reg) < 3'h4) else $error("illegal operation started");
    a_halt_bounded: assert property (halt_cnt <= HALT_MAX)
        else $error("halt never released");
    a_halt_length: assert property ($fell(cpu_halt) |-> halt_cnt == halt_cycles(op_reg, div_reg))
        else $error("halt length off");
    a_cmd_zero: assert property (rd && paddr == `OFS_COMMAND_UNLOCK |-> prdata == 32'h0)
        else $error("command port readable");
    a_hole_zero: assert property (rd && paddr == 12'h040 |-> prdata == 32'h0)
        else $error("unmapped read nonzero");
    a_idle_data: assert property (!(psel && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read");
endmodule

//--- tb/flash_self_programming_engine_tb.sv
// self-checking bench for the flash self-programming engine
`timescale 1ns/100ps
`include "flash_engine_consts.vh"
module flash_self_programming_engine_tb;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        running_in_boot = 1;
    logic [3:0]  boot_strap = 4'h2;
    logic        cpu_halt;
    logic [15:0] seed = 16'h1CD2;
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic [31:0] exp_q[$];
    int          halt_q[$];
    int          halt_len = 0;
    int          err_count = 0;
    int          n_checks = 0;
    int          div = 0;
    always #50 pclk = ~pclk;
    flash_self_programming_engine dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .running_in_boot(running_in_boot),
        .boot_size_strap(boot_strap), .lower_bound_strap(8'hF0), .cpu_halt(cpu_halt));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int ticks(input logic [2:0] c);
        return c == `OP_ERASE ? `ERASE_TICKS : c == `OP_PROGRAM ? `PROGRAM_TICKS : `READ_TICKS;
    endfunction
    task automatic check(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready === 1'b1) begin
            psel <= 0;
            penable <= 0;
        end else begin
            check(0, "bus timeout");
            conclude();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(0, a, 32'h0);
    endtask
    // read data is judged here, apart from the driver
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            if (exp_q.size() == 0) check(0, "unexpected read");
            else check(prdata === exp_q.pop_front(), "read data");
        end
    end
    // halt length is judged here against the oldest noted expectation
    always @(posedge pclk) begin
        if (cpu_halt === 1'b1) begin
            halt_len++;
        end else if (halt_len > 0) begin
            if (halt_q.size() == 0) check(0, "unexpected halt");
            else check(halt_len == halt_q.pop_front(), "halt length");
            halt_len = 0;
        end
    end
    task automatic op(input logic [2:0] c, input logic [14:0] a, input logic [7:0] d,
                      input logic run, input logic brk);
        int n;
        int hi;
        wr(`OFS_OPERATION_TYPE, {5'h0, c});
        wr(`OFS_ADDRESS_HIGH, {1'b0, a[14:8]});
        wr(`OFS_ADDRESS_LOW, a[7:0]);
        wr(`OFS_DATA_BYTE, d);
        if (run) halt_q.push_back(ticks(c) * (div + 1) + 1);
        wr(`OFS_COMMAND_UNLOCK, `UNLOCK_FIRST);
        if (brk) wr(`OFS_COMMAND_UNLOCK, 8'h00);
        wr(`OFS_COMMAND_UNLOCK, `UNLOCK_SECOND);
        hi = 0;
        for (n = 0; n < 250 && !(hi > 0 && cpu_halt === 1'b0); n++) begin
            @(posedge pclk);
            if (cpu_halt === 1'b1) hi++;
        end
        check((hi > 0) === run, "halt presence");
        check(cpu_halt === 1'b0, "halt release");
    endtask
    task automatic byte_is(input logic [14:0] a, input logic [7:0] e);
        op(`OP_READ, a, 8'h00, 1, 0);
        rd(`OFS_DATA_BYTE, {24'h0, e});
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        rd(`OFS_LOWER_BOUND, 32'hF0);
        rd(`OFS_CLOCK_CONTROL, {26'h0, `DIVIDER_RESET});
        rd(12'h040, 32'h0);
        wr(`OFS_LOWER_BOUND, 8'hE8);
        rd(`OFS_LOWER_BOUND, 32'hE8);
        wr(`OFS_LOWER_BOUND, 8'hF0);
        wr(`OFS_ACCESS_CONTROL, 8'h80);
        wr(`OFS_CLOCK_CONTROL, 8'h00);
        $display("test registers done");
        seed = lfsr(seed);
        d1 = seed[7:0];
        seed = lfsr(seed);
        d2 = seed[7:0];
        op(`OP_ERASE, 15'h0000, 8'h00, 1, 0);
        op(`OP_PROGRAM, 15'h0005, d1, 1, 0);
        op(`OP_PROGRAM, 15'h0005, d2, 1, 0);
        byte_is(15'h0005, d1 & d2);
        byte_is(15'h01FF, 8'hFF);
        wr(`OFS_CLOCK_CONTROL, 8'h01);
        div = 1;
        op(`OP_ERASE, 15'h0000, 8'h00, 1, 0);
        byte_is(15'h0005, 8'hFF);
        $display("test boot side done");
        running_in_boot <= 0;
        op(`OP_PROGRAM, 15'h0005, 8'h00, 0, 0);
        rd(`OFS_STATUS, 32'h4);
        byte_is(15'h0005, 8'hFF);
        op(`OP_ERASE, 15'h7800, 8'h00, 1, 0);
        op(`OP_PROGRAM, 15'h7801, d1, 1, 0);
        byte_is(15'h7801, d1);
        op(`OP_PROGRAM, 15'h77FF, 8'h00, 0, 0);
        op(`OP_PROGRAM, 15'h7BFF, 8'h00, 1, 0);
        op(`OP_PROGRAM, 15'h7C00, 8'h00, 0, 0);
        op(`OP_READ, 15'h7C00, 8'h00, 0, 0);
        boot_strap <= 4'h0;
        op(`OP_READ, 15'h7FFF, 8'h00, 1, 0);
        boot_strap <= 4'hF;
        op(`OP_READ, 15'h7000, 8'h00, 0, 0);
        op(`OP_READ, 15'h6FFF, 8'h00, 1, 0);
        boot_strap <= 4'h2;
        $display("test application side done");
        wr(`OFS_ACCESS_CONTROL, 8'h00);
        op(`OP_READ, 15'h7801, 8'h00, 0, 0);
        wr(`OFS_ACCESS_CONTROL, 8'h80);
        op(`OP_READ, 15'h7801, 8'h00, 0, 1);
        for (int c = 0; c < 8; c++) begin
            if (c == 0 || c > 3) op(c[2:0], 15'h7801, 8'h00, 0, 0);
        end
        wr(`OFS_OPERATION_TYPE, {5'h0, `OP_STANDBY});
        wr(`OFS_ACCESS_CONTROL, 8'h00);
        $display("test refusals done");
        check(exp_q.size() == 0 && halt_q.size() == 0, "results left over");
        conclude();
    end
endmodule
bind flash_self_programming_engine flash_self_programming_engine_monitor mon_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .running_in_boot(running_in_boot), .boot_size_strap(boot_size_strap),
    .lower_bound_strap(lower_bound_strap), .cpu_halt(cpu_halt));
